// ### hw/dsr_pkg.sv
// shared constants, states and small helpers for the receive demodulator/decoder
// assumes one 44 MHz-class sample clock drives every block that imports it
package dsr_pkg;
	localparam int DSR_ADC_W      = 3;
	localparam int DSR_MIX_W      = 7;
	localparam int DSR_PH_W       = 8;
	localparam int DSR_NCO_W      = 16;
	localparam int DSR_SCR_LEN    = 7;
	localparam int DSR_FREQ_SHIFT = 4;
	localparam int DSR_LEAD_SHIFT = 4;
	localparam int DSR_ROT_BIT_A  = 5;
	localparam int DSR_ROT_BIT_B  = 6;
	// sample clock pulses per high-rate symbol, last index and shortened last index
	localparam logic [4:0] DSR_SYM_LAST   = 5'h1f;
	localparam logic [4:0] DSR_SYM_SHORT  = 5'h1e;
	localparam logic [1:0] DSR_END_PH     = 2'h0;
	localparam logic [1:0] DSR_MID_PH     = 2'h2;
	localparam logic [3:0] DSR_FREQ_LAST  = 4'hf;
	localparam logic [4:0] DSR_TRACK_LAST = 5'h1f;
	localparam logic [2:0] DSR_SEED_SYMS  = 3'h7;
	localparam logic [1:0] DSR_MODE_DBPSK = 2'h0;
	localparam logic [1:0] DSR_MODE_DQPSK = 2'h1;
	localparam logic [1:0] DSR_MODE_BINARY_BIORTHOGONAL_MODE = 2'h2;
	localparam logic [1:0] DSR_MODE_QUAD_BIORTHOGONAL_MODE = 2'h3;
	localparam logic [7:0] DSR_QUAD_HALF  = 8'h20;
	localparam logic [7:0] DSR_BIN_HALF   = 8'h40;

	typedef enum logic [1:0] {DSR_ST_ACQ, DSR_ST_SEARCH, DSR_ST_LOWRATE, DSR_ST_HIGHRATE} dsr_state_t;

	// nearest constellation point of an 8-bit phase, in quarter turns
	function automatic logic [1:0] dsr_quant(input logic [7:0] ph, input logic quad);
		logic [7:0] r;
		r = quad ? ph + DSR_QUAD_HALF : ph + DSR_BIN_HALF;
		dsr_quant = quad ? r[7:6] : {r[7], 1'b0};
	endfunction

	// eight-entry cosine table, amplitude three
	function automatic logic signed [DSR_MIX_W-1:0] dsr_cos(input logic [2:0] idx);
		case (idx)
			3'h0: dsr_cos = 7'sh03;
			3'h1: dsr_cos = 7'sh02;
			3'h2: dsr_cos = 7'sh00;
			3'h3: dsr_cos = -7'sh02;
			3'h4: dsr_cos = -7'sh03;
			3'h5: dsr_cos = -7'sh02;
			3'h6: dsr_cos = 7'sh00;
			default: dsr_cos = 7'sh02;
		endcase
	endfunction
endpackage

// ### hw/dsr_walsh_bank.sv
// one bank of eight serial walsh correlators with a biggest picker
// assumes chip_stb marks each decimated chip and sym_end comes a few pulses after the last one
`timescale 1ns/1ns
`default_nettype none
module dsr_walsh_bank
	import dsr_pkg::*;
#(
	parameter int IN_W  = DSR_MIX_W,
	parameter int ACC_W = 10
)(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [IN_W-1:0]  chip,
	input  wire logic             chip_stb,
	input  wire logic [2:0]       chip_idx,
	input  wire logic             sym_end,
	output logic      [2:0]       pick_idx,
	output logic                  pick_neg,
	output logic                  pick_stb
);
	if (ACC_W < IN_W + 3)
	begin : g_acc_check
		$error("accumulator too narrow for eight chips");
	end

	logic signed [ACC_W-1:0] acc_ff [8];
	logic signed [ACC_W-1:0] nxt_acc [8];
	logic signed [ACC_W-1:0] sum [8];
	logic signed [ACC_W-1:0] chip_x;
	logic [ACC_W-1:0]        best_mag;
	logic [2:0]              best;
	logic [2:0]              idx_ff, nxt_idx;
	logic                    neg_ff, nxt_neg, stb_ff;

	function automatic logic [ACC_W-1:0] mag(input logic signed [ACC_W-1:0] v);
		mag = v[ACC_W-1] ? ACC_W'(-v) : v;
	endfunction

	always_comb
	begin
		chip_x = ACC_W'(signed'(chip));
		best = 3'h0;
		best_mag = '0;
		for (int k = 0; k < 8; k++)
		begin
			// matched to walsh k or its inverse
			sum[k] = acc_ff[k];
			if (chip_stb)
				sum[k] = ^(3'(k) & chip_idx) ? acc_ff[k] - chip_x : acc_ff[k] + chip_x;
			nxt_acc[k] = sym_end ? '0 : sum[k];
		end
		for (int k = 0; k < 8; k++)
		begin
			if (mag(sum[k]) > best_mag)
			begin
				best_mag = mag(sum[k]);
				best = 3'(k);
			end
		end
		nxt_idx = sym_end ? best : idx_ff;
		nxt_neg = sym_end ? sum[best][ACC_W-1] : neg_ff;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int k = 0; k < 8; k++)
				acc_ff[k] <= '0;
			idx_ff <= 3'h0;
			neg_ff <= 1'b0;
			stb_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= nxt_acc;
			idx_ff <= nxt_idx;
			neg_ff <= nxt_neg;
			stb_ff <= sym_end;
		end
	end

	assign pick_idx = idx_ff;
	assign pick_neg = neg_ff;
	assign pick_stb = stb_ff;
endmodule // dsr_walsh_bank
`default_nettype wire

// ### hw/dsr_descrambler.sv
// self-synchronising descrambler, seven-stage register holding received bits
// assumes taps come steady from the scrambler tap configuration
`timescale 1ns/1ns
`default_nettype none
module dsr_descrambler
	import dsr_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   in_bit,
	input  wire logic                   in_stb,
	input  wire logic [DSR_SCR_LEN-1:0] taps,
	output logic                        out_bit,
	output logic                        out_stb
);
	logic [DSR_SCR_LEN-1:0] sr_ff, nxt_sr;
	logic                   bit_ff, nxt_bit, stb_ff;

	always_comb
	begin
		nxt_sr = sr_ff;
		nxt_bit = bit_ff;
		if (in_stb)
		begin
			nxt_bit = in_bit ^ (^(sr_ff & taps));
			nxt_sr = {sr_ff[DSR_SCR_LEN-2:0], in_bit};
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sr_ff <= '0;
			bit_ff <= 1'b0;
			stb_ff <= 1'b0;
		end
		else
		begin
			sr_ff <= nxt_sr;
			bit_ff <= nxt_bit;
			stb_ff <= in_stb;
		end
	end

	assign out_bit = bit_ff;
	assign out_stb = stb_ff;
endmodule // dsr_descrambler
`default_nettype wire

// ### hw/dsr_rx_demod.sv
// receive demodulation and decoding: low-rate psk decode, delimiter search timeout,
// high-rate walsh demodulator with chip and carrier tracking, descrambled bit stream
// assumes acquisition logic on the same clock supplies peak phases and lock flags;
// converter samples come from pins and are synchronised here
`timescale 1ns/1ns
`default_nettype none
module dsr_rx_demod
	import dsr_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [DSR_ADC_W-1:0] adc_i,
	input  wire logic [DSR_ADC_W-1:0] adc_q,
	input  wire logic                 acq_done,
	input  wire logic                 carrier_locked,
	input  wire logic                 lr_sym_stb,
	input  wire logic [DSR_PH_W-1:0]  lr_phase,
	input  wire logic                 sfd_found,
	input  wire logic                 hdr_last_bit,
	input  wire logic                 end_of_frame,
	input  wire logic [1:0]           rate_mode,
	input  wire logic [7:0]           txrx_control_reg,
	input  wire logic [7:0]           scrambler_tap_reg,
	input  wire logic [7:0]           delimiter_search_timeout_reg,
	output logic                      rx_bit,
	output logic                      rx_bit_stb,
	output logic                      rx_data_valid,
	output logic                      acq_restart,
	output logic                      coherent_mode,
	output logic                      hr_active,
	output logic [15:0]               phase_variance_quality,
	output logic [DSR_NCO_W-1:0]      freq_estimate
);
	// pin synchronisers
	logic [DSR_ADC_W-1:0] i_meta_ff, i_ff, q_meta_ff, q_ff;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			i_meta_ff <= '0;
			i_ff <= '0;
			q_meta_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			i_meta_ff <= adc_i;
			i_ff <= i_meta_ff;
			q_meta_ff <= adc_q;
			q_ff <= q_meta_ff;
		end
	end

	// control and low-rate decode
	dsr_state_t        state_ff, nxt_state;
	logic [7:0]        tmo_ff, nxt_tmo;
	logic [2:0]        seed_ff, nxt_seed;
	logic              coh_ff, nxt_coh, restart_ff, nxt_restart, valid_ff, nxt_valid;
	logic              hra_ff, nxt_hra;
	logic [7:0]        prev_raw_ff, nxt_prev_raw;
	logic [1:0]        prev_q_ff, nxt_prev_q, ref_ff, nxt_ref;
	logic [3:0]        favg_ff, nxt_favg;
	logic signed [11:0] esum_ff, nxt_esum;
	logic [17:0]       esq_ff, nxt_esq;
	logic [15:0]       var_ff, nxt_var;
	logic [DSR_NCO_W-1:0] phase_ff;
	logic [7:0]        sym_ph, x_ph;
	logic [1:0]        q_cur, qd;
	logic signed [7:0] e_ph, lr_mean;
	logic              quad, rev, lr_ld, lr_upd;
	logic [1:0]        lr_n;
	logic [7:0]        lr_bits;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_tmo = tmo_ff;
		nxt_seed = seed_ff;
		nxt_coh = coh_ff;
		nxt_restart = 1'b0;
		nxt_valid = valid_ff;
		nxt_hra = hra_ff;
		nxt_prev_raw = prev_raw_ff;
		nxt_prev_q = prev_q_ff;
		nxt_ref = ref_ff;
		nxt_favg = favg_ff;
		nxt_esum = esum_ff;
		nxt_esq = esq_ff;
		nxt_var = var_ff;
		quad = (rate_mode != DSR_MODE_DBPSK);
		rev = txrx_control_reg[DSR_ROT_BIT_A] | txrx_control_reg[DSR_ROT_BIT_B];
		sym_ph = lr_phase - phase_ff[DSR_NCO_W-1 -: DSR_PH_W];
		// raw phase delta before lock, derotated phase after
		x_ph = coh_ff ? sym_ph : lr_phase - prev_raw_ff;
		q_cur = dsr_quant(x_ph, quad);
		qd = coh_ff ? q_cur - prev_q_ff : q_cur;
		// reversed rotation sense negates the phase change
		if (rev)
			qd = 2'h0 - qd;
		e_ph = signed'(x_ph - {q_cur, 6'h00});
		lr_mean = 8'(esum_ff >>> DSR_FREQ_SHIFT);
		lr_ld = 1'b0;
		lr_upd = 1'b0;
		lr_n = 2'h1;
		lr_bits = 8'h00;
		// quadrature dibit map, earliest bit in the msb
		if (quad)
		begin
			lr_n = 2'h2;
			lr_bits = {qd[1], qd[1] ^ qd[0], 6'h00};
		end
		// binary bit is the half-turn difference
		else
			lr_bits = {qd[1], 7'h00};
		unique case (state_ff)
			DSR_ST_ACQ:
			begin
				nxt_coh = 1'b0;
				nxt_valid = 1'b0;
				nxt_hra = 1'b0;
				nxt_tmo = 8'h00;
				nxt_seed = 3'h0;
				nxt_favg = 4'h0;
				nxt_esum = '0;
				nxt_esq = '0;
				if (acq_done)
					nxt_state = DSR_ST_SEARCH;
			end
			DSR_ST_SEARCH, DSR_ST_LOWRATE:
			begin
				if (carrier_locked)
					nxt_coh = 1'b1;
				if (lr_sym_stb)
				begin
					lr_ld = 1'b1;
					nxt_prev_raw = lr_phase;
					// absolute decision kept, so the first coherent symbol has a true reference
					nxt_prev_q = dsr_quant(sym_ph, quad);
					if (seed_ff != DSR_SEED_SYMS)
						nxt_seed = seed_ff + 3'h1;
					// valid on the edge that completes the seventh symbol
					nxt_valid = (nxt_seed == DSR_SEED_SYMS);
					nxt_favg = favg_ff + 4'h1;
					nxt_esum = esum_ff + 12'(e_ph);
					// widen before squaring: an 8-bit product would wrap
					nxt_esq = esq_ff + 18'(e_ph) * 18'(e_ph);
					if (favg_ff == DSR_FREQ_LAST)
					begin
						lr_upd = 1'b1;
						nxt_var = 16'(nxt_esq >> DSR_FREQ_SHIFT) - 16'(lr_mean) * 16'(lr_mean);
						nxt_esum = '0;
						nxt_esq = '0;
					end
				end
				if (state_ff == DSR_ST_SEARCH)
				begin
					if (lr_sym_stb)
						nxt_tmo = tmo_ff + 8'h01;
					if (sfd_found)
						nxt_state = DSR_ST_LOWRATE;
					else if (tmo_ff >= delimiter_search_timeout_reg)
					begin
						nxt_restart = 1'b1;
						nxt_state = DSR_ST_ACQ;
					end
				end
				// capture absolute phase, hand over to high rate
				else if (hdr_last_bit && rate_mode[1])
				begin
					nxt_ref = dsr_quant(sym_ph, 1'b1);
					nxt_hra = 1'b1;
					nxt_state = DSR_ST_HIGHRATE;
				end
				else if (end_of_frame)
					nxt_state = DSR_ST_ACQ;
			end
			DSR_ST_HIGHRATE:
			begin
				// high-rate flag drops with the return to acquisition
				if (end_of_frame)
				begin
					nxt_state = DSR_ST_ACQ;
					nxt_hra = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff <= DSR_ST_ACQ;
			tmo_ff <= 8'h00;
			seed_ff <= 3'h0;
			coh_ff <= 1'b0;
			restart_ff <= 1'b0;
			valid_ff <= 1'b0;
			hra_ff <= 1'b0;
			prev_raw_ff <= 8'h00;
			prev_q_ff <= 2'h0;
			ref_ff <= 2'h0;
			favg_ff <= 4'h0;
			esum_ff <= '0;
			esq_ff <= '0;
			var_ff <= 16'h0000;
		end
		else
		begin
			state_ff <= nxt_state;
			tmo_ff <= nxt_tmo;
			seed_ff <= nxt_seed;
			coh_ff <= nxt_coh;
			restart_ff <= nxt_restart;
			valid_ff <= nxt_valid;
			hra_ff <= nxt_hra;
			prev_raw_ff <= nxt_prev_raw;
			prev_q_ff <= nxt_prev_q;
			ref_ff <= nxt_ref;
			favg_ff <= nxt_favg;
			esum_ff <= nxt_esum;
			esq_ff <= nxt_esq;
			var_ff <= nxt_var;
		end
	end

	// high-rate timing, mixer, chip tracking and nco
	logic [4:0]              cnt_ff, nxt_cnt, tsym_ff, nxt_tsym;
	logic                    stall_ff, nxt_stall, adv_ff, nxt_adv, ret_ff, nxt_ret;
	logic                    mid_ff, nxt_mid, pend_ff, nxt_pend;
	logic signed [7:0]       trk_ff, nxt_trk;
	logic [DSR_NCO_W-1:0]    nxt_phase, freq_ff, nxt_freq;
	logic signed [DSR_MIX_W-1:0] i7, q7, c7, s7, mix_i, mix_q;
	logic signed [7:0]       perr;
	logic                    hr, wrap, end_stb, mid_stb, sym_end;

	always_comb
	begin
		hr = (state_ff == DSR_ST_HIGHRATE);
		i7 = DSR_MIX_W'(signed'(i_ff));
		q7 = DSR_MIX_W'(signed'(q_ff));
		c7 = dsr_cos(phase_ff[DSR_NCO_W-1 -: 3]);
		s7 = dsr_cos(phase_ff[DSR_NCO_W-1 -: 3] - 3'h2);
		mix_i = i7 * c7 + q7 * s7;
		mix_q = q7 * c7 - i7 * s7;
		wrap = (cnt_ff == DSR_SYM_LAST) || (adv_ff && cnt_ff == DSR_SYM_SHORT);
		sym_end = hr && wrap && !stall_ff;
		// two samples per chip: end feeds correlators, mid feeds tracking
		end_stb = hr && (cnt_ff[1:0] == DSR_END_PH) && !stall_ff;
		mid_stb = hr && (cnt_ff[1:0] == DSR_MID_PH);
		nxt_cnt = cnt_ff + 5'h01;
		nxt_stall = 1'b0;
		nxt_adv = adv_ff;
		nxt_ret = ret_ff;
		nxt_mid = mid_ff;
		nxt_pend = pend_ff;
		nxt_trk = trk_ff;
		nxt_tsym = tsym_ff;
		// costas phase detector on end samples
		perr = mix_i[DSR_MIX_W-1] ? 8'(-mix_q) : 8'(mix_q);
		if (rate_mode == DSR_MODE_QUAD_BIORTHOGONAL_MODE)
			perr = perr - (mix_q[DSR_MIX_W-1] ? 8'(-mix_i) : 8'(mix_i));
		nxt_freq = freq_ff;
		nxt_phase = phase_ff + freq_ff;
		// low-rate loop takes the sixteen-symbol mean
		if (lr_upd && coh_ff)
			nxt_freq = freq_ff + DSR_NCO_W'(lr_mean);
		if (wrap)
		begin
			nxt_adv = 1'b0;
			// a late step holds the counter one pulse
			if (ret_ff && !stall_ff)
			begin
				nxt_cnt = cnt_ff;
				nxt_stall = 1'b1;
				nxt_ret = 1'b0;
			end
			else
				nxt_cnt = 5'h00;
		end
		if (end_stb)
		begin
			// error only across a transition, sign from later end
			if (mid_ff && (pend_ff != mix_i[DSR_MIX_W-1]))
				nxt_trk = mix_i[DSR_MIX_W-1] ? trk_ff - 8'sh01 : trk_ff + 8'sh01;
			nxt_pend = mix_i[DSR_MIX_W-1];
			nxt_mid = 1'b0;
			// lead/lag filter, loop state inherited from low rate
			nxt_freq = freq_ff + DSR_NCO_W'(perr);
			nxt_phase = phase_ff + freq_ff + (DSR_NCO_W'(perr) <<< DSR_LEAD_SHIFT);
		end
		if (mid_stb)
			nxt_mid = 1'b1;
		if (sym_end)
		begin
			nxt_tsym = tsym_ff + 5'h01;
			// one timing decision per thirty-two symbols
			if (tsym_ff == DSR_TRACK_LAST)
			begin
				nxt_adv = (nxt_trk > 8'sh00);
				nxt_ret = (nxt_trk < 8'sh00);
				nxt_trk = 8'sh00;
			end
		end
		// nco and timing idle outside a frame so each frame starts clean
		if (state_ff == DSR_ST_ACQ)
		begin
			nxt_freq = '0;
			nxt_phase = '0;
		end
		if (!hr)
		begin
			nxt_cnt = 5'h00;
			nxt_tsym = 5'h00;
			nxt_trk = 8'sh00;
			nxt_adv = 1'b0;
			nxt_ret = 1'b0;
			nxt_mid = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_ff <= 5'h00;
			tsym_ff <= 5'h00;
			stall_ff <= 1'b0;
			adv_ff <= 1'b0;
			ret_ff <= 1'b0;
			mid_ff <= 1'b0;
			pend_ff <= 1'b0;
			trk_ff <= 8'sh00;
			freq_ff <= '0;
			phase_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			tsym_ff <= nxt_tsym;
			stall_ff <= nxt_stall;
			adv_ff <= nxt_adv;
			ret_ff <= nxt_ret;
			mid_ff <= nxt_mid;
			pend_ff <= nxt_pend;
			trk_ff <= nxt_trk;
			freq_ff <= nxt_freq;
			phase_ff <= nxt_phase;
		end
	end

	logic [2:0] ii, qi;
	logic       in_neg, qn_neg, pstb, pstb_q;

	dsr_walsh_bank #(.IN_W(DSR_MIX_W), .ACC_W(10)) u_bank_i (
		.clk      (clk),
		.rst      (rst),
		.chip     (mix_i),
		.chip_stb (end_stb),
		.chip_idx (cnt_ff[4:2]),
		.sym_end  (sym_end),
		.pick_idx (ii),
		.pick_neg (in_neg),
		.pick_stb (pstb)
	);

	dsr_walsh_bank #(.IN_W(DSR_MIX_W), .ACC_W(10)) u_bank_q (
		.clk      (clk),
		.rst      (rst),
		.chip     (mix_q),
		.chip_stb (end_stb),
		.chip_idx (cnt_ff[4:2]),
		.sym_end  (sym_end),
		.pick_idx (qi),
		.pick_neg (qn_neg),
		.pick_stb (pstb_q)
	);

	// serializer into the descrambler
	logic [7:0] ser_ff, nxt_ser;
	logic [3:0] sn_ff, nxt_sn;
	logic       sbit_ff, nxt_sbit, sstb_ff, nxt_sstb;
	logic [3:0] ci, cq;

	always_comb
	begin
		// rotate decisions by the captured reference
		unique case (ref_ff)
			2'h0: {ci, cq} = {ii, in_neg, qi, qn_neg};
			2'h1: {ci, cq} = {qi, qn_neg, ii, ~in_neg};
			2'h2: {ci, cq} = {ii, ~in_neg, qi, ~qn_neg};
			2'h3: {ci, cq} = {qi, ~qn_neg, ii, in_neg};
		endcase
		nxt_ser = {ser_ff[6:0], 1'b0};
		nxt_sn = (sn_ff != 4'h0) ? sn_ff - 4'h1 : 4'h0;
		nxt_sbit = ser_ff[7];
		nxt_sstb = (sn_ff != 4'h0);
		if (lr_ld)
		begin
			nxt_ser = lr_bits;
			nxt_sn = {2'h0, lr_n};
		end
		// binary mode sends ci only, the in-phase decision after rotation by the reference
		else if (pstb && pstb_q)
		begin
			nxt_ser = (rate_mode == DSR_MODE_QUAD_BIORTHOGONAL_MODE) ? {ci, cq} : {ci, 4'h0};
			nxt_sn = (rate_mode == DSR_MODE_QUAD_BIORTHOGONAL_MODE) ? 4'h8 : 4'h4;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ser_ff <= 8'h00;
			sn_ff <= 4'h0;
			sbit_ff <= 1'b0;
			sstb_ff <= 1'b0;
		end
		else
		begin
			ser_ff <= nxt_ser;
			sn_ff <= nxt_sn;
			sbit_ff <= nxt_sbit;
			sstb_ff <= nxt_sstb;
		end
	end

	// taps from the tap configuration register
	dsr_descrambler u_descr (
		.clk     (clk),
		.rst     (rst),
		.in_bit  (sbit_ff),
		.in_stb  (sstb_ff),
		.taps    (scrambler_tap_reg[DSR_SCR_LEN-1:0]),
		.out_bit (rx_bit),
		.out_stb (rx_bit_stb)
	);

	assign rx_data_valid = valid_ff;
	assign acq_restart = restart_ff;
	assign coherent_mode = coh_ff;
	assign hr_active = hra_ff;
	assign phase_variance_quality = var_ff;
	assign freq_estimate = freq_ff;
endmodule // dsr_rx_demod
`default_nettype wire

// ### verification/dsr_rx_demod_monitor.sv
// port checker for the receive demodulator, bound into the design
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module dsr_rx_demod_monitor
	import dsr_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       acq_done,
	input wire logic       carrier_locked,
	input wire logic       lr_sym_stb,
	input wire logic       sfd_found,
	input wire logic       hdr_last_bit,
	input wire logic       end_of_frame,
	input wire logic [1:0] rate_mode,
	input wire logic       rx_bit_stb,
	input wire logic       rx_data_valid,
	input wire logic       acq_restart,
	input wire logic       coherent_mode,
	input wire logic       hr_active
);
	logic       on_ff, nxt_on;
	logic [2:0] seed_ff, nxt_seed;
	// tracks search, low rate and high rate; clears one edge late on a restart so valid can drop
	always_comb
	begin
		nxt_on = (on_ff | acq_done) & ~(acq_restart | end_of_frame | rst);
		nxt_seed = on_ff ? seed_ff : 3'h0;
		if (on_ff && lr_sym_stb && !hr_active && seed_ff != DSR_SEED_SYMS)
			nxt_seed = seed_ff + 3'h1;
		if (rst)
			nxt_seed = 3'h0;
	end
	always_ff @(posedge clk)
	begin
		on_ff <= nxt_on;
		seed_ff <= nxt_seed;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take(logic [1:0] m);
		lr_sym_stb && on_ff && sfd_found && !hr_active && rate_mode == m;
	endsequence
	sequence s_burst8;
		rx_bit_stb[*8] ##1 !rx_bit_stb;
	endsequence
	chk_reset_quiet: assert property ($fell(rst) |->
		!(rx_bit_stb | rx_data_valid | acq_restart | hr_active | coherent_mode))
		else $error("outputs not quiet after reset");
	chk_quad_dibit: assert property (s_take(DSR_MODE_DQPSK) |->
		##3 rx_bit_stb ##1 rx_bit_stb ##1 !rx_bit_stb) else $error("dibit timing wrong");
	chk_bin_bit: assert property (s_take(DSR_MODE_DBPSK) |->
		##3 rx_bit_stb ##1 !rx_bit_stb) else $error("binary bit timing wrong");
	chk_restart_cause: assert property (acq_restart |->
		on_ff && !$past(sfd_found) ##1 !acq_restart) else $error("restart pulse wrong");
	chk_seed_wait: assert property (rx_data_valid |-> seed_ff == DSR_SEED_SYMS)
		else $error("data valid before seeding");
	chk_hr_entry: assert property (hdr_last_bit && on_ff && sfd_found && rate_mode[1]
		|=> hr_active) else $error("high rate not entered");
	chk_hr_leave: assert property (end_of_frame && hr_active |=> !hr_active)
		else $error("high rate not left");
	chk_quad_burst: assert property (hr_active && rate_mode == DSR_MODE_QUAD_BIORTHOGONAL_MODE
		&& $rose(rx_bit_stb) |-> s_burst8) else $error("quad burst not eight bits");
	chk_bin_burst: assert property (hr_active && rate_mode == DSR_MODE_BINARY_BIORTHOGONAL_MODE
		&& $rose(rx_bit_stb) |-> rx_bit_stb[*4] ##1 !rx_bit_stb)
		else $error("binary burst not four bits");
	chk_coherent_on: assert property (carrier_locked && on_ff && sfd_found
		&& !end_of_frame |-> ##[1:2] coherent_mode) else $error("coherent mode missing");
endmodule // dsr_rx_demod_monitor
bind dsr_rx_demod dsr_rx_demod_monitor mon_u (.clk, .rst, .acq_done, .carrier_locked,
	.lr_sym_stb, .sfd_found, .hdr_last_bit, .end_of_frame, .rate_mode, .rx_bit_stb,
	.rx_data_valid, .acq_restart, .coherent_mode, .hr_active);
`default_nettype wire

// ### verification/dsr_adc_model.sv
// converter-side model: spread chips on i and q, two samples per chip
// assumes the bench clock is the sample clock; samples move on its falling edge
`timescale 1ns/1ns
`default_nettype none
module dsr_adc_model
	import dsr_pkg::*;
(
	input  wire logic                 clk,
	output logic      [DSR_ADC_W-1:0] adc_i,
	output logic      [DSR_ADC_W-1:0] adc_q
);
	logic [6:0] chips_ff = 7'h5b;
	logic [1:0] ph_ff    = 2'h0;
	initial
	begin
		adc_i = 3'h3;
		adc_q = 3'h0;
	end
	// a sample every second clock, a new chip every second sample
	always @(negedge clk)
	begin
		ph_ff <= ph_ff + 2'h1;
		if (ph_ff[0])
		begin
			adc_i <= chips_ff[0] ? 3'h3 : 3'h5;
			adc_q <= chips_ff[3] ? 3'h1 : 3'h7;
		end
		if (ph_ff == 2'h3)
			chips_ff <= {chips_ff[5:0], chips_ff[6] ^ chips_ff[5]};
	end
endmodule // dsr_adc_model
`default_nettype wire

// ### verification/dsr_rx_demod_tb.sv
// self-checking bench for the receive demodulator, one task per scenario
// assumes the converter model drives the sample pins; inputs move on falling edges
`timescale 1ns/1ns
`default_nettype none
module dsr_rx_demod_tb
	import dsr_pkg::*;
;
	localparam logic [7:0] PRE = 8'h02;
	logic clk = 1'h0, rst = 1'h1, acq_done = 1'h0, carrier_locked = 1'h0, lr_sym_stb = 1'h0;
	logic sfd_found = 1'h0, hdr_last_bit = 1'h0, end_of_frame = 1'h0, rs_seen = 1'h0;
	logic [7:0] lr_phase = 8'h00, txrx_control_reg = 8'h00, scrambler_tap_reg = 8'h00;
	logic [7:0] delimiter_search_timeout_reg = 8'hff;
	logic [1:0] rate_mode = 2'h0, got;
	logic [DSR_ADC_W-1:0] adc_i, adc_q;
	logic rx_bit, rx_bit_stb, rx_data_valid, acq_restart, coherent_mode, hr_active;
	logic [15:0] phase_variance_quality;
	logic [DSR_NCO_W-1:0] freq_estimate;
	int n_errors = 0, samples_checked = 0, ng, cyc = 0;

	dsr_adc_model adc_u (.clk, .adc_i, .adc_q);
	dsr_rx_demod dut_u (.clk, .rst, .adc_i, .adc_q, .acq_done, .carrier_locked, .lr_sym_stb,
		.lr_phase, .sfd_found, .hdr_last_bit, .end_of_frame, .rate_mode, .txrx_control_reg,
		.scrambler_tap_reg, .delimiter_search_timeout_reg, .rx_bit, .rx_bit_stb,
		.rx_data_valid, .acq_restart, .coherent_mode, .hr_active, .phase_variance_quality,
		.freq_estimate);

	initial
		forever #10 clk = ~clk;
	// the scenarios need about 1200 cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("FAIL %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic start(input logic [1:0] m, input logic [7:0] t, input logic s);
		rst = 1'h1;
		tick(4);
		rst = 1'h0;
		rate_mode = m;
		delimiter_search_timeout_reg = t;
		sfd_found = s;
		rs_seen = 1'h0;
		lr_phase = 8'h00;
		acq_done = 1'h1;
		tick(1);
		acq_done = 1'h0;
	endtask

	// one symbol advanced by d; 11 cycles leaves the serializer drained
	task automatic sym(input logic [7:0] d);
		lr_phase = lr_phase + d;
		lr_sym_stb = 1'h1;
		tick(1);
		lr_sym_stb = 1'h0;
		got = 2'h0;
		ng = 0;
		repeat (10)
		begin
			tick(1);
			if (acq_restart === 1'h1)
				rs_seen = 1'h1;
			if (rx_bit_stb === 1'h1)
				got = {got[0], rx_bit};
			if (rx_bit_stb === 1'h1)
				ng++;
		end
	endtask

	task automatic wait_stb(input logic lvl, inout int n);
		while (rx_bit_stb !== lvl && n < 80)
		begin
			tick(1);
			n++;
		end
	endtask

	task automatic t_quad();
		logic [7:0] dl [4] = '{8'h00, 8'h40, 8'h80, 8'hc0};
		logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		start(DSR_MODE_DQPSK, 8'hff, 1'h1);
		sym(8'h00);
		for (int k = 0; k < 4; k++)
		begin
			sym(dl[k]);
			chk("dibit", {6'h0, ex[k]}, {6'h0, got});
		end
		chk("dibit_count", 8'h02, ng[7:0]);
		txrx_control_reg = 8'h20;
		sym(8'h40);
		chk("dibit_reversed_a", 8'h02, {6'h0, got});
		txrx_control_reg = 8'h40;
		sym(8'hc0);
		chk("dibit_reversed_b", 8'h01, {6'h0, got});
		txrx_control_reg = 8'h00;
	endtask

	// first bits depend on unknown register history, so checks start at bit 8
	task automatic t_bin();
		logic [39:0] pat = 40'h9c_5a3e_61b7;
		logic [6:0] sr = 7'h00;
		logic e;
		start(DSR_MODE_DBPSK, 8'hff, 1'h1);
		scrambler_tap_reg = 8'h48;
		// standing phase offset: zero error before lock, eight per symbol after
		lr_phase = 8'h08;
		for (int k = 0; k < 40; k++)
		begin
			carrier_locked = (k >= 20);
			sym(pat[k] ? 8'h80 : 8'h00);
			e = pat[k] ^ (^(sr & scrambler_tap_reg[6:0]));
			sr = {sr[5:0], pat[k]};
			if (k == 5 || k == 6)
				chk("data_valid", {7'h0, k == 6}, {7'h0, rx_data_valid});
			if (k >= 8 && (k < 20 || k >= 28))
				chk("descrambled", {7'h0, e}, {7'h0, got[0]});
		end
		chk("coherent", 8'h01, {7'h0, coherent_mode});
		chk("freq_est", 8'h05, freq_estimate[7:0]);
		chk("variance", 8'h13, phase_variance_quality[7:0]);
		scrambler_tap_reg = 8'h00;
		carrier_locked = 1'h0;
	endtask

	task automatic t_tmo(input logic [7:0] t, input logic s, input logic [7:0] ex);
		int k;
		start(DSR_MODE_DBPSK, t, s);
		k = 0;
		repeat (3)
		begin
			tick(1);
			if (acq_restart === 1'h1)
				rs_seen = 1'h1;
		end
		while (rs_seen !== 1'h1 && k < 24)
		begin
			sym(8'h00);
			k++;
		end
		chk("symbols_to_restart", ex, k[7:0]);
	endtask

	task automatic t_high(input logic [1:0] m, input logic [7:0] nb);
		int len, gap;
		start(DSR_MODE_DQPSK, 8'hff, 1'h1);
		sym(8'h40);
		rate_mode = m;
		hdr_last_bit = 1'h1;
		tick(1);
		hdr_last_bit = 1'h0;
		tick(1);
		chk("hr_entry", 8'h01, {7'h0, hr_active});
		len = 0;
		wait_stb(1'h1, len);
		len = 0;
		wait_stb(1'h0, len);
		chk("burst_bits", nb, len[7:0]);
		gap = len;
		wait_stb(1'h1, gap);
		samples_checked++;
		if (gap < 31 || gap > 33)
		begin
			n_errors++;
			$display("FAIL symbol_period expected 32 seen %0d", gap);
		end
		end_of_frame = 1'h1;
		tick(1);
		end_of_frame = 1'h0;
		tick(1);
		chk("hr_leave", 8'h00, {7'h0, hr_active});
	endtask

	initial
	begin
		tick(1);
		t_quad();
		t_bin();
		t_tmo(8'h00, 1'h0, 8'h00);
		t_tmo(8'h03, 1'h0, 8'h03);
		t_tmo(PRE + 8'h10, 1'h0, PRE + 8'h10);
		t_tmo(8'h03, 1'h1, 8'h18);
		t_high(DSR_MODE_QUAD_BIORTHOGONAL_MODE, 8'h08);
		t_high(DSR_MODE_BINARY_BIORTHOGONAL_MODE, 8'h04);
		conclude();
	end
endmodule // dsr_rx_demod_tb
`default_nettype wire
